// ### hdl/pgm_top.v
// pulse generator and two measure counters behind an AXI4-Lite slave
`timescale 1ns/1ps
`include "pgm_consts.vh"
module pgm_top #(
   parameter PIPE_DEPTH = `PIPE_DEPTH_DEF
) (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // axi4-lite write address
   input  wire [7:0]  awaddr,
   input  wire        awvalid,
   output wire        awready,
   // axi4-lite write data
   input  wire [31:0] wdata,
   input  wire [3:0]  wstrb,
   input  wire        wvalid,
   output wire        wready,
   // axi4-lite write response
   output wire [1:0]  bresp,
   output wire        bvalid,
   input  wire        bready,
   // axi4-lite read address
   input  wire [7:0]  araddr,
   input  wire        arvalid,
   output wire        arready,
   // axi4-lite read data
   output wire [31:0] rdata,
   output wire [1:0]  rresp,
   output wire        rvalid,
   input  wire        rready,
   // external pins
   input  wire        ctClkPin,
   input  wire        ctGatePin,
   input  wire        tachPin,
   input  wire [7:0]  dinPin,
   output wire        pulseOutPin,
   // sample stream from the acquisition sequencer
   input  wire        convDone,
   input  wire        sampleReq,
   input  wire [4:0]  sampleChan,
   output wire        sampleOutValid,
   output wire [4:0]  sampleOutChan,
   output wire [31:0] sampleOutData
);
   // ****************************************************************
   // register bus
   // ****************************************************************
   reg         awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
   reg  [1:0]  bresp_q, rresp_q;
   reg  [31:0] rdata_q;
   reg         awHeld_q, wHeld_q;
   reg  [7:0]  awAddr_q;
   reg  [31:0] wData_q;
   reg  [3:0]  wStrb_q;
   reg  [31:0] ctrl_q, div_q, period_q, active_q, mc1Cfg_q, mc2Cfg_q;
   reg         chan16_q;
   reg  [31:0] rdMux;
   reg         rdHit;
   wire        pgRunning, pgDone, pgOut;
   wire [31:0] mc1Latch, mc2Latch;
   wire        mc1Busy, mc2Busy;
   assign awready = awready_q;
   assign wready  = wready_q;
   assign bvalid  = bvalid_q;
   assign bresp   = bresp_q;
   assign arready = arready_q;
   assign rvalid  = rvalid_q;
   assign rresp   = rresp_q;
   assign rdata   = rdata_q;
   function [31:0] mergeStrb;
      input [31:0] old;
      input [31:0] nw;
      input [3:0]  strb;
      integer b;
      begin
         mergeStrb = old;
         for (b = 0; b < 4; b = b + 1) begin
            if (strb[b])
               mergeStrb[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
   endfunction
   function isWritable;
      input [7:0] a;
      begin
         isWritable = (a == `OFS_PG_CTRL) || (a == `OFS_PG_DIV) ||
                      (a == `OFS_PG_PERIOD) || (a == `OFS_PG_ACTIVE) ||
                      (a == `OFS_MC1_CFG) || (a == `OFS_MC2_CFG) ||
                      (a == `OFS_CHAN_CFG);
      end
   endfunction
   wire       doWrite  = awHeld_q && wHeld_q && !bvalid_q;
   wire [7:0] wAddr    = {awAddr_q[7:2], 2'b00};
   wire       pgCfgWr  = doWrite && (wAddr == `OFS_PG_CTRL);
   wire       mc1CfgWr = doWrite && (wAddr == `OFS_MC1_CFG);
   wire       mc2CfgWr = doWrite && (wAddr == `OFS_MC2_CFG);
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         awHeld_q  <= 1'b0;
         wHeld_q   <= 1'b0;
         awAddr_q  <= 8'h00;
         wData_q   <= 32'h0000_0000;
         wStrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= `RESP_OKAY;
         ctrl_q    <= `RST_PG_CTRL;
         div_q     <= `RST_PG_DIV;
         period_q  <= `RST_PG_PERIOD;
         active_q  <= `RST_PG_ACTIVE;
         mc1Cfg_q  <= `RST_MC_CFG;
         mc2Cfg_q  <= `RST_MC_CFG;
         chan16_q  <= 1'b0;
      end else begin
         if (awvalid && awready_q) begin
            awAddr_q  <= awaddr;
            awHeld_q  <= 1'b1;
            awready_q <= 1'b0;
         end
         if (wvalid && wready_q) begin
            wData_q  <= wdata;
            wStrb_q  <= wstrb;
            wHeld_q  <= 1'b1;
            wready_q <= 1'b0;
         end
         if (doWrite) begin
            awHeld_q <= 1'b0;
            wHeld_q  <= 1'b0;
            bvalid_q <= 1'b1;
            bresp_q  <= isWritable(wAddr) ? `RESP_OKAY : `RESP_SLVERR;
            case (wAddr)
               `OFS_PG_CTRL:   ctrl_q   <= mergeStrb(ctrl_q, wData_q, wStrb_q);
               `OFS_PG_DIV:    div_q    <= mergeStrb(div_q, wData_q, wStrb_q);
               `OFS_PG_PERIOD: period_q <= mergeStrb(period_q, wData_q, wStrb_q);
               `OFS_PG_ACTIVE: active_q <= mergeStrb(active_q, wData_q, wStrb_q);
               `OFS_MC1_CFG:   mc1Cfg_q <= mergeStrb(mc1Cfg_q, wData_q, wStrb_q);
               `OFS_MC2_CFG:   mc2Cfg_q <= mergeStrb(mc2Cfg_q, wData_q, wStrb_q);
               `OFS_CHAN_CFG: begin
                  if (wStrb_q[0])
                     chan16_q <= wData_q[0];
               end
               default: chan16_q <= chan16_q;
            endcase
         end
         if (bvalid_q && bready) begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end
   always @* begin
      rdHit = 1'b1;
      case ({araddr[7:2], 2'b00})
         `OFS_PG_CTRL:   rdMux = ctrl_q;
         `OFS_PG_DIV:    rdMux = div_q;
         `OFS_PG_PERIOD: rdMux = period_q;
         `OFS_PG_ACTIVE: rdMux = active_q;
         `OFS_PG_STATUS: rdMux = {29'h0000_0000, pgOut, pgDone, pgRunning};
         `OFS_MC1_CFG:   rdMux = mc1Cfg_q;
         `OFS_MC2_CFG:   rdMux = mc2Cfg_q;
         `OFS_MC1_LATCH: rdMux = mc1Latch;
         `OFS_MC2_LATCH: rdMux = mc2Latch;
         `OFS_CHAN_CFG:  rdMux = {31'h0000_0000, chan16_q};
         `OFS_MC_STATUS: rdMux = {30'h0000_0000, mc2Busy, mc1Busy};
         default: begin
            rdMux = 32'h0000_0000;
            rdHit = 1'b0;
         end
      endcase
   end
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= `RESP_OKAY;
      end else begin
         if (arvalid && arready_q) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rdata_q   <= rdMux;
            rresp_q   <= rdHit ? `RESP_OKAY : `RESP_SLVERR;
         end
         if (rvalid_q && rready) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
         end
      end
   end
   // ****************************************************************
   // pin synchronisers and edge detection
   // ****************************************************************
   // order: gate, clock, tach, din[7:0]
   reg  [10:0] syncA_q, syncB_q, prev_q;
   wire [10:0] rise = syncB_q & ~prev_q;
   wire [10:0] fall = ~syncB_q & prev_q;
   reg  [`EV_NUM-1:0] events;
   integer i;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         syncA_q <= 11'h000;
         syncB_q <= 11'h000;
         prev_q  <= 11'h000;
      end else begin
         syncA_q <= {ctGatePin, ctClkPin, tachPin, dinPin};
         syncB_q <= syncA_q;
         prev_q  <= syncB_q;
      end
   end
   always @* begin
      events    = {`EV_NUM{1'b0}};
      events[0] = convDone;
      events[1] = fall[8];
      events[2] = rise[8];
      for (i = 0; i < 8; i = i + 1) begin
         events[3 + 2*i] = fall[i];
         events[4 + 2*i] = rise[i];
      end
      events[19] = fall[9];
      events[20] = rise[9];
      events[21] = fall[10];
      events[22] = rise[10];
   end
   // ****************************************************************
   // counter clock for the pulse engine
   // ****************************************************************
   localparam [31:0] DIV_MIN = (`PG_DIV_MIN_CALC > `PG_DIV_FLOOR) ?
                               `PG_DIV_MIN_CALC : `PG_DIV_FLOOR;
   localparam [31:0] EXT_GAP_W = `PG_EXT_MIN_CYC - 1;
   localparam [7:0]  EXT_GAP = EXT_GAP_W[7:0];
   reg  [31:0] preCnt_q;
   reg  [7:0]  extGap_q;
   // clamping trades exact small dividers for a guaranteed rate ceiling
   wire [31:0] divEff  = (div_q < DIV_MIN) ? DIV_MIN : div_q;
   wire        intTick = (preCnt_q == divEff - 32'h0000_0001);
   wire        extTick = rise[9] && (extGap_q >= EXT_GAP);
   wire        tick    = ctrl_q[`PG_CTRL_EXTCLK] ? extTick : intTick;
   always @(posedge clk_sys) begin
      if (!rst_n || pgCfgWr) begin
         preCnt_q <= 32'h0000_0000;
         extGap_q <= 8'h00;
      end else begin
         // divider restarts with each run so the first pulse spans whole ticks
         preCnt_q <= (intTick || !pgRunning) ? 32'h0000_0000 : preCnt_q + 32'h0000_0001;
         if (extTick)
            extGap_q <= 8'h00;
         else if (extGap_q != 8'hFF)
            extGap_q <= extGap_q + 8'h01;
      end
   end
   pulse_gen u_pulse (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .mode      (ctrl_q[`PG_CTRL_MODE_LSB +: 2]),
      .gateHigh  (ctrl_q[`PG_CTRL_GATEHI]),
      .polHigh   (ctrl_q[`PG_CTRL_POLHI]),
      .period    (period_q),
      .activeCnt (active_q),
      .cfgWr     (pgCfgWr),
      .tick      (tick),
      .gateLvl   (syncB_q[10]),
      .gateRise  (rise[10]),
      .gateFall  (fall[10]),
      .pulseOut  (pgOut),
      .running   (pgRunning),
      .done      (pgDone)
   );
   assign pulseOutPin = pgOut;
   // ****************************************************************
   // measure counters
   // ****************************************************************
   measure_counter #(.WIDTH(32)) u_mc1 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .startSel (mc1Cfg_q[`MC_CFG_START_LSB +: 5]),
      .stopSel  (mc1Cfg_q[`MC_CFG_STOP_LSB +: 5]),
      .enable   (mc1Cfg_q[`MC_CFG_EN]),
      .cfgWr    (mc1CfgWr),
      .events   (events),
      .latch_q  (mc1Latch),
      .busy_q   (mc1Busy)
   );
   measure_counter #(.WIDTH(32)) u_mc2 (
      .clk_sys  (clk_sys),
      .rst_n    (rst_n),
      .startSel (mc2Cfg_q[`MC_CFG_START_LSB +: 5]),
      .stopSel  (mc2Cfg_q[`MC_CFG_STOP_LSB +: 5]),
      .enable   (mc2Cfg_q[`MC_CFG_EN]),
      .cfgWr    (mc2CfgWr),
      .events   (events),
      .latch_q  (mc2Latch),
      .busy_q   (mc2Busy)
   );
   // ****************************************************************
   // sample stream with group-delay pipeline
   // ****************************************************************
   // sampling never disturbs the latch, so fast sampling repeats the value
   wire [4:0] ch1   = chan16_q ? `CH_MC1_16 : `CH_MC1_8;
   wire [4:0] ch2   = chan16_q ? `CH_MC2_16 : `CH_MC2_8;
   wire       hit1  = sampleReq && (sampleChan == ch1);
   wire       hit2  = sampleReq && (sampleChan == ch2);
   reg        pipeValid_q [0:PIPE_DEPTH-1];
   reg [4:0]  pipeChan_q  [0:PIPE_DEPTH-1];
   reg [31:0] pipeData_q  [0:PIPE_DEPTH-1];
   integer k;
   always @(posedge clk_sys) begin
      if (!rst_n) begin
         for (k = 0; k < PIPE_DEPTH; k = k + 1) begin
            pipeValid_q[k] <= 1'b0;
            pipeChan_q[k]  <= 5'h00;
            pipeData_q[k]  <= 32'h0000_0000;
         end
      end else begin
         pipeValid_q[0] <= hit1 || hit2;
         pipeChan_q[0]  <= sampleChan;
         pipeData_q[0]  <= hit1 ? mc1Latch : (hit2 ? mc2Latch : 32'h0000_0000);
         for (k = 1; k < PIPE_DEPTH; k = k + 1) begin
            pipeValid_q[k] <= pipeValid_q[k-1];
            pipeChan_q[k]  <= pipeChan_q[k-1];
            pipeData_q[k]  <= pipeData_q[k-1];
         end
      end
   end
   assign sampleOutValid = pipeValid_q[PIPE_DEPTH-1];
   assign sampleOutChan  = pipeChan_q[PIPE_DEPTH-1];
   assign sampleOutData  = pipeData_q[PIPE_DEPTH-1];
endmodule

// ### hdl/pgm_consts.vh
// constants shared by the pulse generator and measure counter block
`ifndef PGM_CONSTS_VH
`define PGM_CONSTS_VH
// ****************************************************************
// clocking, rate limits and sample pipeline depth
// ****************************************************************
`define SYS_CLK_HZ        50000000
`define PG_INT_FMAX_HZ    24000000
`define PG_EXT_FMAX_HZ    5000000
`define PG_DIV_FLOOR      2
`define PG_DIV_MIN_CALC   ((`SYS_CLK_HZ + `PG_INT_FMAX_HZ - 1) / `PG_INT_FMAX_HZ)
`define PG_EXT_MIN_CYC    ((`SYS_CLK_HZ + `PG_EXT_FMAX_HZ - 1) / `PG_EXT_FMAX_HZ)
`define PIPE_DEPTH_DEF    4
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_PG_CTRL       8'h00
`define OFS_PG_DIV        8'h04
`define OFS_PG_PERIOD     8'h08
`define OFS_PG_ACTIVE     8'h0C
`define OFS_PG_STATUS     8'h10
`define OFS_MC1_CFG       8'h14
`define OFS_MC2_CFG       8'h18
`define OFS_MC1_LATCH     8'h1C
`define OFS_MC2_LATCH     8'h20
`define OFS_CHAN_CFG      8'h24
`define OFS_MC_STATUS     8'h28
// ****************************************************************
// fields and reset values
// ****************************************************************
`define PG_CTRL_MODE_LSB  0
`define PG_CTRL_EXTCLK    2
`define PG_CTRL_GATEHI    3
`define PG_CTRL_POLHI     4
`define MC_CFG_START_LSB  0
`define MC_CFG_STOP_LSB   8
`define MC_CFG_EN         16
`define RST_PG_CTRL       32'h0000_0000
`define RST_PG_DIV        32'h0000_0002
`define RST_PG_PERIOD     32'h0000_0002
`define RST_PG_ACTIVE     32'h0000_0001
`define RST_MC_CFG        32'h0000_0000
`define MODE_OFF          2'h0
`define MODE_RATE         2'h1
`define MODE_ONESHOT      2'h2
`define MODE_REPSHOT      2'h3
// ****************************************************************
// event selector codes, stream channels and bus response codes
// ****************************************************************
`define EV_NUM            23
`define EV_CONV           5'h00
`define CH_MC1_8          5'h0A
`define CH_MC2_8          5'h0B
`define CH_MC1_16         5'h12
`define CH_MC2_16         5'h13
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
`endif

// ### hdl/pulse_gen.v
// pulse output engine: rate generation, one-shot and repetitive one-shot
`timescale 1ns/1ps
`include "pgm_consts.vh"
module pulse_gen (
   // clock and reset
   input  wire        clk_sys,
   input  wire        rst_n,
   // configuration
   input  wire [1:0]  mode,
   input  wire        gateHigh,
   input  wire        polHigh,
   input  wire [31:0] period,
   input  wire [31:0] activeCnt,
   input  wire        cfgWr,
   // timing and gate
   input  wire        tick,
   input  wire        gateLvl,
   input  wire        gateRise,
   input  wire        gateFall,
   // status and output
   output reg         pulseOut,
   output wire        running,
   output wire        done
);
   localparam [3:0] S_IDLE = 4'b0001;
   localparam [3:0] S_RATE = 4'b0010;
   localparam [3:0] S_SHOT = 4'b0100;
   localparam [3:0] S_HALT = 4'b1000;
   reg  [3:0]  state_q;
   reg  [31:0] phase_q;
   wire [31:0] perEff   = (period == 32'h0000_0000) ? 32'h0000_0001 : period;
   wire        gateOn   = gateHigh ? gateLvl : !gateLvl;
   wire        gateEdge = gateHigh ? gateRise : gateFall;
   wire        lastTick = tick && (phase_q == perEff - 32'h0000_0001);
   reg         active;
   assign running = state_q[1] | state_q[2];
   assign done    = state_q[3];
   always @* begin
      case (state_q)
         S_RATE:  active = (phase_q < activeCnt);
         S_SHOT:  active = 1'b1;
         default: active = 1'b0;
      endcase
   end
   always @(posedge clk_sys) begin
      if (!rst_n || cfgWr) begin
         state_q  <= S_IDLE;
         phase_q  <= 32'h0000_0000;
         pulseOut <= 1'b0;
      end else begin
         pulseOut <= active ? polHigh : !polHigh;
         case (state_q)
            S_IDLE: begin
               phase_q <= 32'h0000_0000;
               if (mode == `MODE_RATE && gateOn)
                  state_q <= S_RATE;
               else if ((mode == `MODE_ONESHOT || mode == `MODE_REPSHOT) && gateEdge)
                  state_q <= S_SHOT;
            end
            S_RATE: begin
               if (mode != `MODE_RATE || !gateOn) begin
                  state_q <= S_IDLE;
                  phase_q <= 32'h0000_0000;
               end else if (tick) begin
                  phase_q <= lastTick ? 32'h0000_0000 : phase_q + 32'h0000_0001;
               end
            end
            S_SHOT: begin
               // gate edges are not looked at here, so a pulse is never retriggered
               if (lastTick) begin
                  phase_q <= 32'h0000_0000;
                  state_q <= (mode == `MODE_ONESHOT) ? S_HALT : S_IDLE;
               end else if (tick) begin
                  phase_q <= phase_q + 32'h0000_0001;
               end
            end
            S_HALT:  state_q <= S_HALT;
            default: state_q <= S_IDLE;
         endcase
      end
   end
endmodule

// ### hdl/measure_counter.v
// edge-to-edge interval counter with latched result
`timescale 1ns/1ps
`include "pgm_consts.vh"
module measure_counter #(
   parameter WIDTH = 32
) (
   // clock and reset
   input  wire             clk_sys,
   input  wire             rst_n,
   // configuration
   input  wire [4:0]       startSel,
   input  wire [4:0]       stopSel,
   input  wire             enable,
   input  wire             cfgWr,
   // event sources
   input  wire [`EV_NUM-1:0] events,
   // result
   output reg  [WIDTH-1:0] latch_q,
   output reg              busy_q
);
   reg  [WIDTH-1:0] cnt_q;
   function evPick;
      input [`EV_NUM-1:0] ev;
      input [4:0]         sel;
      begin
         evPick = (sel < `EV_NUM) ? ev[sel] : 1'b0;
      end
   endfunction
   wire startHit = evPick(events, startSel);
   wire stopHit  = evPick(events, stopSel);
   wire sameEdge = (startSel == stopSel);
   always @(posedge clk_sys) begin
      if (!rst_n || cfgWr || !enable) begin
         cnt_q   <= {WIDTH{1'b0}};
         busy_q  <= 1'b0;
         latch_q <= {WIDTH{1'b0}};
      end else if (busy_q) begin
         // count one per clock; plain binary wrap on overflow
         cnt_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
         if (stopHit) begin
            // result holds elapsed clocks plus one
            latch_q <= cnt_q + {{(WIDTH-1){1'b0}}, 1'b1};
            if (sameEdge) begin
               cnt_q <= {{(WIDTH-1){1'b0}}, 1'b1};
            end else begin
               cnt_q  <= {WIDTH{1'b0}};
               busy_q <= 1'b0;
            end
         end
      end else if (startHit) begin
         cnt_q  <= {{(WIDTH-1){1'b0}}, 1'b1};
         busy_q <= 1'b1;
      end
   end
endmodule

// ### sim/pgm_checker_assertions.sv
// port assertions for pgm_top
`timescale 1ns/1ps
module pgm_checker #(parameter int PIPE_DEPTH = 4) (
   input logic        clk_sys, rst_n, awvalid, awready, wvalid, wready, bvalid, bready,
   input logic [7:0]  awaddr, dinPin,
   input logic [31:0] wdata, sampleOutData,
   input logic [1:0]  bresp,
   input logic        ctClkPin, ctGatePin, tachPin, convDone, pulseOutPin,
   input logic        sampleReq, sampleOutValid,
   input logic [4:0]  sampleChan, sampleOutChan
);
   logic [7:0] adr_q;
   logic [4:0] ctl_q, dat_q;
   logic [2:0] hist_q;
   logic       seen_q, halt_q;
   wire calm = awready && &hist_q;
   wire shot = calm && ctl_q[1:0] == 2'h2;
   wire rate = calm && ctl_q[1:0] == 2'h1;
   wire gOn  = ctGatePin == ctl_q[3];
   wire mcIn = sampleChan inside {5'h0A, 5'h0B, 5'h12, 5'h13};
   // control mirror follows answered writes; pulse checks wait until the bus is quiet
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         {adr_q, ctl_q, dat_q, hist_q, seen_q, halt_q} <= 23'h00_0000;
      end else begin
         hist_q <= {hist_q[1:0], awready};
         if (awvalid && awready) adr_q <= awaddr;
         if (wvalid && wready) dat_q <= wdata[4:0];
         if (bvalid && bready && bresp == 2'h0 && adr_q == 8'h00) ctl_q <= dat_q;
         if (convDone || $changed({ctClkPin, ctGatePin, tachPin, dinPin})) seen_q <= 1'b1;
         if (!calm) halt_q <= 1'b0;
         else if (shot && $changed(pulseOutPin) && pulseOutPin != ctl_q[4]) halt_q <= 1'b1;
      end
   end
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   sequence gateOff; (rate && !gOn) [*6]; endsequence
   sequence gateOn; (rate && gOn) [*8]; endsequence
   AST_SAMPLE_DELAY: assert property (sampleOutValid |-> $past(sampleReq, PIPE_DEPTH))
      else $error("stream output without a request");
   AST_SAMPLE_CHAN: assert property (sampleOutValid |-> $past(mcIn, PIPE_DEPTH)
      && sampleOutChan == $past(sampleChan, PIPE_DEPTH)) else $error("wrong stream channel");
   AST_OTHER_SILENT: assert property (sampleReq && !mcIn |-> ##PIPE_DEPTH !sampleOutValid)
      else $error("foreign channel produced output");
   AST_ZERO_FIRST: assert property (sampleOutValid && !seen_q |-> sampleOutData == 32'h0000_0000)
      else $error("count before any measurement");
   AST_RATE_STOP: assert property (gateOff |-> pulseOutPin != ctl_q[4])
      else $error("pulses with gate inactive");
   AST_RATE_SPACING: assert property (gateOn ##0 $changed(pulseOutPin) |=> $stable(pulseOutPin))
      else $error("pulse edges too close");
   AST_SHOT_START: assert property (shot && !halt_q && ctl_q[3] && $rose(ctGatePin)
      && pulseOutPin != ctl_q[4] |-> ##[2:12] pulseOutPin == ctl_q[4]) else $error("no shot");
   AST_SHOT_HALT: assert property (shot && halt_q |-> pulseOutPin != ctl_q[4])
      else $error("output after one-shot ended");
endmodule
bind pgm_top pgm_checker #(.PIPE_DEPTH(PIPE_DEPTH)) chk (.clk_sys, .rst_n, .awvalid, .awready,
   .wvalid, .wready, .bvalid, .bready, .awaddr, .dinPin, .wdata, .sampleOutData, .bresp,
   .ctClkPin, .ctGatePin, .tachPin, .convDone, .pulseOutPin, .sampleReq, .sampleOutValid,
   .sampleChan, .sampleOutChan);

// ### sim/pin_source.sv
// external gate, counter clock, tachometer and digital input sources
`timescale 1ns/1ps
module pin_source (
   input  logic       clk_sys,
   output logic       ctClkPin, ctGatePin, tachPin,
   output logic [7:0] dinPin
);
   // all pins idle low so reset leaves no edge to detect
   initial {ctClkPin, ctGatePin, tachPin, dinPin} = 11'h000;
   task automatic setGate(input logic v);
      @(posedge clk_sys);
      ctGatePin <= v;
   endtask
   // sel 0..7 picks a digital input, 8 the tachometer, 9 the counter clock
   task automatic drive(input int sel, input logic v);
      if (sel == 9) ctClkPin <= v;
      else if (sel == 8) tachPin <= v;
      else dinPin[sel] <= v;
   endtask
   task automatic wave(input int sel, hi, lo, n);
      repeat (n) begin
         @(posedge clk_sys);
         drive(sel, 1'b1);
         repeat (hi) @(posedge clk_sys);
         drive(sel, 1'b0);
         repeat (lo - 1) @(posedge clk_sys);
      end
   endtask
endmodule

// ### sim/test_pulse_gen_and_measure_counters.sv
// self-checking bench for the pulse generator and measure counters
`timescale 1ns/1ps
module test_pulse_gen_and_measure_counters;
   logic clk_sys = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic sampleReq = 0, convDone = 0;
   logic [3:0] wstrb = 4'hF;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0;
   logic [4:0] sampleChan = 0;
   wire awready, wready, bvalid, arready, rvalid, pulseOutPin, sampleOutValid;
   wire ctClkPin, ctGatePin, tachPin;
   wire [1:0] bresp, rresp;
   wire [7:0] dinPin;
   wire [4:0] sampleOutChan;
   wire [31:0] rdata, sampleOutData;
   int num_errors = 0, checks_done = 0, cycles = 0, hiCnt = 0;
   pin_source src (.clk_sys, .ctClkPin, .ctGatePin, .tachPin, .dinPin);
   pgm_top dut (.clk_sys, .rst_n, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
      .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready, .ctClkPin, .ctGatePin, .tachPin, .dinPin, .pulseOutPin, .convDone,
      .sampleReq, .sampleChan, .sampleOutValid, .sampleOutChan, .sampleOutData);
   initial forever #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cycles++;
      hiCnt <= hiCnt + (pulseOutPin === 1'b1);
      if (cycles == 20000) begin
         num_errors++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [32:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge clk_sys);
      {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'h7};
      do begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (awvalid || wvalid);
      do @(posedge clk_sys); while (!bvalid);
      bready <= 1'b0;
      chk(bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      {araddr, arvalid, rready} <= {a, 2'h3};
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      rready <= 1'b0;
      {d, r} = {rdata, rresp};
   endtask
   task automatic smp(input logic [4:0] c, output logic v, output logic [31:0] d);
      @(posedge clk_sys);
      {sampleReq, sampleChan} <= {1'b1, c};
      @(posedge clk_sys);
      sampleReq <= 1'b0;
      {v, d} = 33'h0;
      repeat (8) @(posedge clk_sys) if (sampleOutValid === 1'b1) {v, d} = {1'b1, sampleOutData};
   endtask
   task automatic width(input int n, output logic [31:0] w);
      w = hiCnt;
      repeat (n) @(posedge clk_sys);
      w = hiCnt - w;
   endtask
   task automatic regsAndMeasure();
      logic [31:0] d;
      logic [1:0] r;
      logic v;
      rd(8'h04, d, r); chk(d, 32'h0000_0002);
      rd(8'h0C, d, r); chk(d, 32'h0000_0001);
      rd(8'h3C, d, r); chk(r, 2'h2);
      wr(8'h1C, 32'h0000_0005, 2'h2);
      smp(5'h0A, v, d); chk({v, d}, 33'h1_0000_0000);
      smp(5'h05, v, d); chk(v, 1'b0);
      wr(8'h14, 32'h0001_0202, 2'h0);
      wr(8'h18, 32'h0001_0102, 2'h0);
      src.wave(8, 15, 25, 4);
      smp(5'h0A, v, d); chk(d, 32'h0000_0029);
      smp(5'h0A, v, d); chk(d, 32'h0000_0029);
      smp(5'h0B, v, d); chk(d, 32'h0000_0010);
      src.wave(8, 10, 20, 3);
      wstrb <= 4'hE;
      wr(8'h24, 32'h0000_0001, 2'h0);
      wstrb <= 4'hF;
      rd(8'h24, d, r); chk(d, 32'h0000_0000);
      wr(8'h24, 32'h0000_0001, 2'h0);
      smp(5'h12, v, d); chk(d, 32'h0000_001F);
      smp(5'h13, v, d); chk(d, 32'h0000_000B);
      smp(5'h0A, v, d); chk(v, 1'b0);
   endtask
   task automatic pulses();
      logic [31:0] w;
      wr(8'h00, 32'h0000_001A, 2'h0);
      // a quiet bus lets the start assertion look at this edge
      repeat (3) @(posedge clk_sys);
      src.setGate(1'b1); width(40, w); chk(w, 32'h0000_0006);
      src.setGate(1'b0); src.setGate(1'b1); width(40, w); chk(w, 32'h0000_0000);
      wr(8'h08, 32'h0000_0004, 2'h0);
      wr(8'h00, 32'h0000_001B, 2'h0);
      repeat (2) begin
         w = hiCnt;
         src.setGate(1'b0); src.setGate(1'b1); repeat (5) @(posedge clk_sys);
         src.setGate(1'b0); src.setGate(1'b1); repeat (60) @(posedge clk_sys);
         chk(hiCnt - w, 32'h0000_000C);
      end
      wr(8'h00, 32'h0000_0019, 2'h0);
      repeat (10) @(posedge clk_sys);
      width(48, w); chk(w, 32'h0000_000C);
      src.setGate(1'b0); repeat (8) @(posedge clk_sys);
      width(48, w); chk(w, 32'h0000_0000);
      wr(8'h00, 32'h0000_0001, 2'h0);
      repeat (10) @(posedge clk_sys);
      width(48, w); chk(w, 32'h0000_0024);
   endtask
   task automatic pinsAndConv();
      logic [31:0] d;
      logic v;
      wr(8'h14, 32'h0001_000E, 2'h0);
      wr(8'h18, 32'h0001_1414, 2'h0);
      src.wave(5, 2, 2, 1);
      repeat (6) @(posedge clk_sys);
      convDone <= 1'b1;
      @(posedge clk_sys) convDone <= 1'b0;
      src.wave(9, 4, 4, 3);
      smp(5'h12, v, d); chk(d, 32'h0000_0008);
      smp(5'h13, v, d); chk(d, 32'h0000_0009);
   endtask
   initial begin
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      regsAndMeasure();
      pinsAndConv();
      pulses();
      end_of_test();
   end
endmodule
